// [hdl/ascr_cfg.sv]
// Purpose: configuration registers of a two-axis angle sensor
// Assumes: register port synchronous to clk_i; raw angle from CORDIC
// Notes: the sequencer only paces measurements, no analog model
//
// Notes on behaviour
// (RULE1) alarm high when angle exceeds threshold
// (RULE2) threshold shares angle code, 360 deg = 2^16
// (RULE3) alarm holds while angle stays above
// (RULE4) filter setting 3 bits at 2:0
// (RULE5) oversample select at 10:9, 32..256 samples
// (RULE6) conversion = (points + 69) * 2 us
// (RULE7) standby interval between measurements in loop modes
// (RULE8) each interval count adds 20 ms
// (RULE9) channel gate used when command omits channels
// (RULE10) each gate bit enables one channel
// (RULE11) zero register holds offset bits 15:1
// (RULE12) host writes two's complement of zero angle
// (RULE13) subtract zero reference before report and compare
// (RULE14) reserved bits read zero, ignore writes
`include "ascr_regs.svh"
module ascr_cfg import ascr_pkg::*; #(
    parameter int STBY_CYC = `ASCR_STBY_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // register access port, one 16-bit register per index
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    // measurement control
    input wire logic loop_mode_i, // continuous or wake-up mode
    input wire logic single_i, // one-shot request pulse
    input wire logic [3:0] cmd_chan_i, // channels carried by command
    input wire logic [15:0] raw_angle_i,
    input wire logic raw_valid_i,
    output logic [15:0] angle_o,
    output logic alarm_o,
    output logic [3:0] chan_en_o,
    output logic converting_o,
    output logic meas_done_o
);
    // ======================================================
    // reset synchroniser
    logic rst_s1, rst_n; // two-stage release
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // ======================================================
    // register file
    logic [15:0] thresh; // alarm threshold, angle code
    logic [15:0] sample; // filter and oversample
    logic [15:0] timing; // interval and channel gate
    logic [15:0] zero; // offset bits 15:1 in 14:0

    // writes masked so reserved bits never store
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            thresh <= `ASCR_RST_THRESH;
            sample <= `ASCR_RST_SAMPLE;
            timing <= `ASCR_RST_TIMING;
            zero <= `ASCR_RST_ZERO;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                // (RULE2) threshold raw code
                `ASCR_OFS_THRESH: begin
                    thresh <= reg_wdata_i & `ASCR_MASK_THRESH;
                end
                // (RULE4) filter and oversample
                `ASCR_OFS_SAMPLE: begin
                    sample <= reg_wdata_i & `ASCR_MASK_SAMPLE;
                end
                // (RULE7) interval and gate
                `ASCR_OFS_TIMING: begin
                    timing <= reg_wdata_i & `ASCR_MASK_TIMING;
                end
                // (RULE11) zero reference bits
                `ASCR_OFS_ZERO: begin
                    zero <= reg_wdata_i & `ASCR_MASK_ZERO;
                end
                default: begin
                    // unmapped index: write dropped
                end
            endcase
        end
    end

    // registered read data, unmapped reads as zero
    // (RULE14) reserved bits zero
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= 16'h0000;
        end else begin
            case (reg_addr_i)
                `ASCR_OFS_THRESH: reg_rdata_o <= thresh;
                `ASCR_OFS_SAMPLE: reg_rdata_o <= sample;
                `ASCR_OFS_TIMING: reg_rdata_o <= timing;
                `ASCR_OFS_ZERO: reg_rdata_o <= zero;
                default: reg_rdata_o <= 16'h0000;
            endcase
        end
    end

    // ======================================================
    // field extraction
    logic [2:0] filter_setting;
    logic [1:0] oversample_select;
    logic [5:0] standby_interval;
    logic [3:0] channel_gate;
    assign filter_setting = sample[`ASCR_FLT_LSB +: 3];
    assign oversample_select = sample[`ASCR_OSR_LSB +: 2];
    assign standby_interval = timing[`ASCR_IVL_LSB +: 6];
    assign channel_gate = timing[`ASCR_CHN_LSB +: 4];

    // ======================================================
    // conversion length in 2 us units
    logic [9:0] osr_pts; // samples per measurement
    // 8 * 130 + 69 tops out at 1109, so these need 11 bits
    logic [10:0] adc_pts; // total ADC points
    logic [10:0] conv_units;
    // (RULE5) 32 shifted by oversample code
    assign osr_pts = 10'h020 << oversample_select;
    // (RULE6) points = 2^osr * (2^flt + 2), plus 69
    assign adc_pts = 11'((11'h001 << oversample_select)
        * ((11'h001 << filter_setting) + 11'h002));
    assign conv_units = adc_pts + 11'(`ASCR_CONV_BASE);

    // ======================================================
    // angle path
    logic [15:0] zero_ref; // stored bits with lsb zero
    logic [15:0] angle_corr;
    assign zero_ref = {zero[14:0], 1'b0};
    // (RULE13) add two's complement offset, mod 2^16
    assign angle_corr = raw_angle_i + zero_ref;

    // report and compare the corrected angle
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            angle_o <= 16'h0000;
            alarm_o <= 1'b0;
        end else if (raw_valid_i) begin
            angle_o <= angle_corr;
            // (RULE1) strict greater-than compare
            // (RULE3) held until angle drops back
            alarm_o <= (angle_corr > thresh);
        end
    end

    // ======================================================
    // measurement sequencer
    ascr_state_t state, next_state;
    logic tmr_load, tmr_done;
    logic [10:0] tmr_units;

    ascr_timer #(
        .UNIT_CYC(`ASCR_CONV_CYC),
        .UW(11)
    ) u_conv_tmr (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .load_i(tmr_load & (next_state == ASCR_CONV)),
        .units_i(tmr_units),
        .done_o(tmr_done),
        .busy_o()
    );

    logic stby_done;
    ascr_timer #(
        .UNIT_CYC(STBY_CYC),
        .UW(6)
    ) u_stby_tmr (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .load_i(tmr_load & (next_state == ASCR_WAIT)),
        .units_i(standby_interval),
        .done_o(stby_done),
        .busy_o()
    );

    // next state and timer loads
    always_comb begin
        next_state = state;
        tmr_load = 1'b0;
        tmr_units = conv_units;
        case (state)
            ASCR_IDLE: begin
                if (loop_mode_i || single_i) begin
                    next_state = ASCR_CONV;
                    tmr_load = 1'b1;
                end
            end
            // (RULE6) wait out conversion time
            ASCR_CONV: begin
                if (tmr_done) begin
                    tmr_load = loop_mode_i;
                    // (RULE7) loop modes pause in standby
                    next_state = loop_mode_i ? ASCR_WAIT : ASCR_IDLE;
                end
            end
            // (RULE8) standby of interval times 20 ms
            ASCR_WAIT: begin
                if (stby_done) begin
                    next_state = loop_mode_i ? ASCR_CONV : ASCR_IDLE;
                    tmr_load = loop_mode_i;
                end
            end
            default: begin
                next_state = ASCR_IDLE;
            end
        endcase
    end

    // state register and registered status outputs
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ASCR_IDLE;
            converting_o <= 1'b0;
            meas_done_o <= 1'b0;
        end else begin
            state <= next_state;
            converting_o <= (next_state == ASCR_CONV);
            meas_done_o <= (state == ASCR_CONV) && tmr_done;
        end
    end

    // channel enables latched at measurement start
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            chan_en_o <= 4'h0;
        end else if (tmr_load && next_state == ASCR_CONV) begin
            // (RULE9) fall back to gate when none given
            // (RULE10) one bit per channel
            chan_en_o <= (cmd_chan_i != 4'h0) ? cmd_chan_i : channel_gate;
        end
    end

    // ======================================================
    // checks
    // (RULE1) alarm follows compare
    property p_alarm;
        @(posedge clk_i) disable iff (!rst_n)
        raw_valid_i |=> alarm_o == ($past(angle_corr) > $past(thresh));
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm mismatch"); // RULE1

    // (RULE13) angle corrected by offset
    property p_angle;
        @(posedge clk_i) disable iff (!rst_n)
        raw_valid_i |=> angle_o == 16'($past(raw_angle_i)
            + {$past(zero[14:0]), 1'b0});
    endproperty
    a_angle: assert property (p_angle) else $error("angle wrong"); // RULE13

    // (RULE3) alarm steady without new sample
    property p_hold;
        @(posedge clk_i) disable iff (!rst_n)
        !raw_valid_i |=> $stable(alarm_o);
    endproperty
    a_hold: assert property (p_hold) else $error("alarm moved"); // RULE3

    // (RULE14) reserved bits stay zero
    property p_rsvd;
        @(posedge clk_i) disable iff (!rst_n)
        (sample & ~`ASCR_MASK_SAMPLE) == 16'h0
            && (timing & ~`ASCR_MASK_TIMING) == 16'h0 && !zero[15];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved set"); // RULE14

    // (RULE5) oversample points
    property p_osr;
        @(posedge clk_i) disable iff (!rst_n)
        oversample_select == 2'h3 |-> osr_pts == 10'd256;
    endproperty
    a_osr: assert property (p_osr) else $error("osr points"); // RULE5

    // (RULE6) minimum conversion length
    property p_conv;
        @(posedge clk_i) disable iff (!rst_n)
        $rose(converting_o) |-> converting_o [*8];
    endproperty
    a_conv: assert property (p_conv) else $error("conv short"); // RULE6

    // (RULE4) filter feeds points
    property p_flt;
        @(posedge clk_i) disable iff (!rst_n)
        sample[10:0] == 11'h000 |-> conv_units == 11'd72;
    endproperty
    a_flt: assert property (p_flt) else $error("filter points"); // RULE4

    // (RULE9) gate used when command empty
    property p_gate;
        @(posedge clk_i) disable iff (!rst_n)
        (tmr_load && next_state == ASCR_CONV && cmd_chan_i == 4'h0)
            |=> chan_en_o == $past(channel_gate);
    endproperty
    a_gate: assert property (p_gate) else $error("gate unused"); // RULE9
endmodule : ascr_cfg

// [hdl/ascr_regs.svh]
// Purpose: register offsets, field positions and timing counts
// Assumes: 50 MHz clock, 8-bit register index on the access port
// Notes: definitions only
`ifndef ASCR_REGS_SVH
`define ASCR_REGS_SVH

// ==========================================================
// register indices
`define ASCR_OFS_THRESH 8'h19
`define ASCR_OFS_SAMPLE 8'h1c
`define ASCR_OFS_TIMING 8'h1d
`define ASCR_OFS_ZERO 8'h1e

// ==========================================================
// writable masks (reserved bits read zero)
`define ASCR_MASK_THRESH 16'hffff
`define ASCR_MASK_SAMPLE 16'h0607
`define ASCR_MASK_TIMING 16'h03ff
`define ASCR_MASK_ZERO 16'h7fff

// ==========================================================
// field positions
`define ASCR_FLT_LSB 0
`define ASCR_OSR_LSB 9
`define ASCR_IVL_LSB 0
`define ASCR_CHN_LSB 6

// ==========================================================
// reset values
`define ASCR_RST_THRESH 16'hffff
`define ASCR_RST_SAMPLE 16'h0000
`define ASCR_RST_TIMING 16'h0000
`define ASCR_RST_ZERO 16'h0000

// ==========================================================
// timing
`define ASCR_CLK_MHZ 50
`define ASCR_CONV_US 2
`define ASCR_CONV_BASE 69
`define ASCR_CONV_CYC (`ASCR_CONV_US * `ASCR_CLK_MHZ)
`define ASCR_STBY_MS 20
`define ASCR_STBY_CYC (`ASCR_STBY_MS * 1000 * `ASCR_CLK_MHZ)

`endif

// [hdl/ascr_pkg.sv]
// Purpose: types shared by the configuration block
// Assumes: nothing beyond the register header
// Notes: sequencer states
package ascr_pkg;
    // sequencer states of the measurement loop
    typedef enum logic [1:0] {
        ASCR_IDLE = 2'b00,
        ASCR_CONV = 2'b01,
        ASCR_WAIT = 2'b10
    } ascr_state_t;
endpackage : ascr_pkg

// [hdl/ascr_timer.sv]
// Purpose: loadable down counter measuring units of a base period
// Assumes: base period count fits 32 bits
// Notes: done pulses one cycle when units are exhausted
module ascr_timer #(
    parameter int UNIT_CYC = 100,
    parameter int UW = 10
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [UW-1:0] units_i,
    output logic done_o,
    output logic busy_o
);
    // ======================================================
    // counters
    logic [31:0] tick; // cycles left in current unit
    logic [UW-1:0] left; // units left

    // count cycles then units; zero units finish at once
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick <= 32'h0;
            left <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (load_i) begin
                tick <= 32'(UNIT_CYC - 1);
                left <= units_i;
                busy_o <= 1'b1;
            end else if (busy_o) begin
                if (left == '0) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else if (tick == 32'h0) begin
                    tick <= 32'(UNIT_CYC - 1);
                    left <= left - 1'b1;
                end else begin
                    tick <= tick - 32'h1;
                end
            end
        end
    end
endmodule : ascr_timer

// [tb/ascr_host_model.sv]
// Purpose: far-side model feeding raw angle samples and zero codes
// Assumes: one sample per send request, taken on the rising edge
// Notes: idle angle lines toggle so a stale value is never mistaken
module ascr_host_model (
    input wire logic clk_i,
    input wire logic send_i, // request one sample
    input wire logic [15:0] angle_i, // angle code to present
    output logic [15:0] raw_angle_o,
    output logic raw_valid_o,
    output logic [14:0] zero_code_o // code that zeroes angle_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // zero code
    // two's complement, top bits
    logic [15:0] neg_angle; // inverse plus one of the wanted zero angle
    assign neg_angle = ~angle_i + 16'h0001;
    assign zero_code_o = neg_angle[15:1];

    // ==========================================================
    // sample strobe and data
    // outside a sample the data inverts every cycle, never holds
    always_ff @(posedge clk_i) begin
        raw_valid_o <= send_i;
        if (send_i) begin
            raw_angle_o <= angle_i;
        end else begin
            raw_angle_o <= ~raw_angle_o;
        end
    end
endmodule : ascr_host_model

// [tb/angle_sensor_config_regs_tb_top.sv]
// Purpose: self-checking bench of the configuration block
// Assumes: standby unit shortened to STBY cycles
// Notes: conversion and standby lengths allow a few cycles of slack
`include "ascr_regs.svh"
module angle_sensor_config_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // signals
    localparam int STBY = 50; // shortened 20 ms unit
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic [15:0] reg_rdata_o;
    logic loop_mode_i = 1'b0;
    logic single_i = 1'b0;
    logic [3:0] cmd_chan_i = 4'h0;
    logic [15:0] raw_angle_i;
    logic raw_valid_i;
    logic [15:0] angle_o;
    logic alarm_o;
    logic [3:0] chan_en_o;
    logic converting_o;
    logic meas_done_o;
    logic send = 1'b0; // sample request to the model
    logic [15:0] send_angle = 16'h0000;
    logic [14:0] zero_code;
    logic [15:0] rv; // read value
    int err_total = 0;
    int total_checks = 0;
    int wt; // cycles waited before a conversion
    int ln; // cycles a conversion lasted

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    ascr_cfg #(.STBY_CYC(STBY)) u_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .loop_mode_i(loop_mode_i),
        .single_i(single_i), .cmd_chan_i(cmd_chan_i),
        .raw_angle_i(raw_angle_i), .raw_valid_i(raw_valid_i),
        .angle_o(angle_o), .alarm_o(alarm_o), .chan_en_o(chan_en_o),
        .converting_o(converting_o), .meas_done_o(meas_done_o)
    );

    ascr_host_model u_host (
        .clk_i(clk_i), .send_i(send), .angle_i(send_angle),
        .raw_angle_o(raw_angle_i), .raw_valid_o(raw_valid_i),
        .zero_code_o(zero_code)
    );

    // ==========================================================
    // helpers
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // counts carry slack for the pulse edges around each phase
    task automatic near(input int got, input int exp);
        total_checks++;
        if (got < exp - 4 || got > exp + 4) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : near

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        repeat (2) @(posedge clk_i);
        #1 d = reg_rdata_o;
    endtask : rd

    // one sample through the model, then angle and alarm compared
    task automatic ang(input logic [15:0] a, input logic [15:0] e,
                       input logic al);
        @(posedge clk_i);
        send <= 1'b1;
        send_angle <= a;
        @(posedge clk_i);
        send <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 chk(angle_o, e);
        chk({15'h0000, alarm_o}, {15'h0000, al});
    endtask : ang

    // waits for a conversion, bounded, and measures its length
    task automatic conv(output int w, output int l);
        w = 0;
        l = 0;
        while (converting_o !== 1'b1 && w < 20000) begin
            @(posedge clk_i);
            #1 w++;
        end
        while (converting_o === 1'b1 && l < 20000) begin
            @(posedge clk_i);
            #1 l++;
        end
    endtask : conv

    function automatic int conv_cyc(input int osr, input int flt);
        return ((2 ** osr) * ((2 ** flt) + 2) + `ASCR_CONV_BASE)
               * `ASCR_CONV_CYC;
    endfunction : conv_cyc

    // ==========================================================
    // watchdog, sized well above the longest test sequence
    initial begin
        repeat (60000) @(posedge clk_i);
        err_total++;
        end_sim();
    end

    // ==========================================================
    // tests
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        // reset values and an unmapped index
        rd(`ASCR_OFS_THRESH, rv); chk(rv, 16'hffff);
        rd(`ASCR_OFS_SAMPLE, rv); chk(rv, 16'h0000);
        rd(`ASCR_OFS_TIMING, rv); chk(rv, 16'h0000);
        rd(`ASCR_OFS_ZERO, rv); chk(rv, 16'h0000);
        rd(8'h1a, rv); chk(rv, 16'h0000);
        $display("test reset values done");
        // all ones written: reserved bits stay zero
        wr(`ASCR_OFS_SAMPLE, 16'hffff);
        rd(`ASCR_OFS_SAMPLE, rv); chk(rv, 16'h0607);
        wr(`ASCR_OFS_TIMING, 16'hffff);
        rd(`ASCR_OFS_TIMING, rv); chk(rv, 16'h03ff);
        wr(`ASCR_OFS_ZERO, 16'hffff);
        rd(`ASCR_OFS_ZERO, rv); chk(rv, 16'h7fff);
        wr(8'h1a, 16'hffff);
        rd(8'h1a, rv); chk(rv, 16'h0000);
        $display("test masks done");
        // zero reference from the model's two's complement
        send_angle <= 16'h01aa;
        @(posedge clk_i);
        #1 chk({1'b0, zero_code}, 16'h7f2b);
        wr(`ASCR_OFS_ZERO, {1'b0, zero_code});
        ang(16'h01aa, 16'h0000, 1'b0);
        ang(16'h0000, 16'hfe56, 1'b0);
        $display("test zero offset done");
        // 45 degree threshold, strict compare, level alarm
        wr(`ASCR_OFS_ZERO, 16'h0000);
        wr(`ASCR_OFS_THRESH, 16'((45 * 65536) / 360));
        rd(`ASCR_OFS_THRESH, rv); chk(rv, 16'h2000);
        ang(16'h2000, 16'h2000, 1'b0);
        ang(16'h2001, 16'h2001, 1'b1);
        ang(16'hffff, 16'hffff, 1'b1);
        ang(16'h1fff, 16'h1fff, 1'b0);
        $display("test alarm done");
        // one-shot with command channels, longer filter setting
        wr(`ASCR_OFS_SAMPLE, 16'h0201);
        cmd_chan_i <= 4'h3;
        @(posedge clk_i);
        single_i <= 1'b1;
        @(posedge clk_i);
        single_i <= 1'b0;
        conv(wt, ln);
        near(ln, conv_cyc(1, 1));
        chk({12'h000, chan_en_o}, 16'h0003);
        // done pulse rises with the falling conversion flag, one cycle
        chk({15'h0000, meas_done_o}, 16'h0001);
        @(posedge clk_i);
        #1 chk({15'h0000, meas_done_o}, 16'h0000);
        $display("test single done");
        // loop mode with gate 0x0c and three standby units
        wr(`ASCR_OFS_SAMPLE, 16'h0000);
        wr(`ASCR_OFS_TIMING, (16'h000c << 6) | 16'h0003);
        cmd_chan_i <= 4'h0;
        loop_mode_i <= 1'b1;
        conv(wt, ln);
        near(ln, conv_cyc(0, 0));
        chk({12'h000, chan_en_o}, 16'h000c);
        chk({15'h0000, meas_done_o}, 16'h0001);
        conv(wt, ln);
        near(wt, 3 * STBY);
        // inputs change only on the rising edge
        @(posedge clk_i);
        loop_mode_i <= 1'b0;
        repeat (3 * STBY + 20) @(posedge clk_i);
        #1 chk({15'h0000, converting_o}, 16'h0000);
        $display("test loop done");
        end_sim();
    end
endmodule : angle_sensor_config_regs_tb_top
